// file: ssei_core.sv
// Serial peripheral engine: register port, divider, shifter, interrupts
// Notes on behaviour
// - Phase 0 polarity 0: clock idles low, data half cycle early, sample rising.
// - Phase 0 polarity 1: clock idles high, data half cycle early, sample falling.
// - Phase 1 polarity 0: idle low, drive on rising edges, sample on falling.
// - Phase 1 polarity 1: idle high, drive on falling edges, sample on rising.
// - Phase 0 back to back words get a high chip-select pulse between them.
// - Disabling the port never flushes either FIFO.
// - Serial clock is input clock over even prescale 2..254 times rate plus one.
// - Serial clock duty cycle is always one half.
// - Transmit order field picks byte order and bit order, four encodings.
// - Receive order field uses the same four encodings on incoming words.
// - Orders 00 and 11 for any length; mixed orders for 16, 24, 32 bits.
// - Six sources, mask one enables, single output, raw and masked readable.
// - Receive level high while receive fill count is at or above watermark.
// - Transmit level high while transmit fill count is at or below watermark.
// - Transmit level is reported even while the port is disabled.
// - Timeout raised when receive data waits 32 serial periods unread.
// - Timeout cleared by emptying, by a new frame, or by writing one.
// - Frame into full receive FIFO sets overrun, FIFO untouched, write one clears.
// - Frame with empty transmit FIFO sets underrun, resends stale word.
// - Frame length programmable from 4 to 32 bits.
// - Independent transmit and receive FIFOs, sixteen words of 32 bits.
// - Transmit empty level high whenever the transmit FIFO is empty.
`timescale 1ns/1ps
module ssei_core #(
  parameter int DEPTH = ssei_pkg::FIFO_DEP
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_b,
  input  wire logic [ssei_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [ssei_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [ssei_pkg::DATA_W-1:0] o_rdata,
  output logic                             o_irq,
  output logic                             o_sclk,
  input  wire logic                        i_sclk,
  output logic                             o_cs_b,
  input  wire logic                        i_cs_b,
  input  wire logic                        i_ser_in,
  output logic                             o_ser_out,
  output logic                             o_ser_out_oe
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int DW = ssei_pkg::DATA_W;

  ssei_pkg::ssei_cfg0_t         config_word_zero_reg;
  ssei_pkg::ssei_cfg1_t         config_word_one_reg;
  ssei_pkg::ssei_wmark_t        wmark_reg;
  logic [7:0]                   clock_prescale_register_reg;
  logic [ssei_pkg::NIRQ-1:0]    interrupt_mask_register_reg;
  logic                         timeout_flag_reg;
  logic                         overrun_flag_reg;
  logic                         underrun_flag_reg;
  ssei_pkg::ssei_state_t        state_reg;
  ssei_pkg::ssei_state_t        state_next;
  logic [ssei_pkg::DIV_W-1:0]   div_cnt_reg;
  logic [ssei_pkg::TO_W-1:0]    to_cnt_reg;
  logic [5:0]                   edge_cnt_reg;
  logic [4:0]                   bit_cnt_reg;
  logic [DW-1:0]                tx_sh_reg;
  logic [DW-1:0]                rx_sh_reg;
  logic [DW-1:0]                tx_last_reg;
  logic                         sclk_q_reg;
  logic                         cs_q_reg;
  logic [DW-1:0]                rd_mux;
  logic [ssei_pkg::NIRQ-1:0]    raw_int;
  logic [DW-1:0]                tx_head;
  logic [DW-1:0]                rx_head;
  logic [CW-1:0]                tx_cnt;
  logic [CW-1:0]                rx_cnt;
  logic                         tx_full;
  logic                         tx_empty;
  logic                         rx_full;
  logic                         rx_empty;

  // Byte swap and bit reversal within the low frame bits; each is its own inverse
  function automatic logic [DW-1:0] reorder(input logic [DW-1:0] w,
                                            input logic [4:0]    lm1,
                                            input logic [1:0]    ord);
    logic [DW-1:0] m;
    logic [DW-1:0] r;
    int            nb;
    m  = w & ~(ssei_pkg::LOW_MASK << lm1);
    r  = m;
    nb = (int'(lm1) + 1) / ssei_pkg::BYTE_W;
    case (ord)
      ssei_pkg::ORD_LSB_LSB: begin
        for (int i = 0; i < DW; i++) begin
          if (i <= int'(lm1)) begin
            r[i] = m[int'(lm1) - i];
          end
        end
      end
      ssei_pkg::ORD_LSB_MSB: begin
        for (int j = 0; j < DW / ssei_pkg::BYTE_W; j++) begin
          if (j < nb) begin
            r[j*ssei_pkg::BYTE_W +: ssei_pkg::BYTE_W] = m[(nb-1-j)*ssei_pkg::BYTE_W +: ssei_pkg::BYTE_W];
          end
        end
      end
      ssei_pkg::ORD_MSB_LSB: begin
        for (int j = 0; j < DW / ssei_pkg::BYTE_W; j++) begin
          for (int k = 0; k < ssei_pkg::BYTE_W; k++) begin
            if (j < nb) begin
              r[j*ssei_pkg::BYTE_W + k] = m[j*ssei_pkg::BYTE_W + ssei_pkg::BYTE_W - 1 - k];
            end
          end
        end
      end
      default: r = m;
    endcase
    return r;
  endfunction

  function automatic logic [4:0] fix_len(input logic [4:0] v);
    return (v < ssei_pkg::LEN_M1_MIN) ? ssei_pkg::LEN_M1_MIN : v;
  endfunction

  // Odd values drop their low bit so the half period stays whole
  function automatic logic [7:0] fix_psc(input logic [7:0] v);
    return ({v[7:1], 1'b0} < ssei_pkg::PSC_MIN) ? ssei_pkg::PSC_MIN : {v[7:1], 1'b0};
  endfunction

  wire       en   = config_word_one_reg.port_enable_bit;
  wire       mst  = config_word_one_reg.master_role;
  wire       cpha = config_word_zero_reg.clock_phase_select;
  wire       cpol = config_word_zero_reg.clock_polarity_select;
  wire [4:0] lm1  = config_word_zero_reg.frame_len_m1;

  wire wr_cfg0 = i_wr && i_addr == ssei_pkg::OFF_CONFIG_WORD_ZERO;
  wire wr_cfg1 = i_wr && i_addr == ssei_pkg::OFF_CONFIG_WORD_ONE;
  wire wr_psc  = i_wr && i_addr == ssei_pkg::OFF_CLOCK_PRESCALE;
  wire wr_mask = i_wr && i_addr == ssei_pkg::OFF_INT_MASK;
  wire wr_clr  = i_wr && i_addr == ssei_pkg::OFF_INT_CLEAR;
  wire wr_wm   = i_wr && i_addr == ssei_pkg::OFF_WATERMARK;
  wire tx_push = i_wr && i_addr == ssei_pkg::OFF_DATA;
  wire rx_pop  = i_rd && i_addr == ssei_pkg::OFF_DATA;

  // Half period is (prescale/2)*(rate+1), so both clock phases are equal
  wire [ssei_pkg::DIV_W-1:0] half_m1 = ssei_pkg::DIV_W'(32'(clock_prescale_register_reg[7:1]) *
    (32'(config_word_zero_reg.serial_clock_rate_field) + 32'd1) - 32'd1);
  wire tick    = en && div_cnt_reg == half_m1;
  wire running = en && state_reg == ssei_pkg::ST_RUN;
  wire m_edge  = mst && running && tick;
  wire s_lead  = !mst && running && !i_cs_b && sclk_q_reg == cpol && i_sclk != cpol;
  wire s_trail = !mst && running && !i_cs_b && sclk_q_reg != cpol && i_sclk == cpol;
  wire lead_ev  = m_edge ? !edge_cnt_reg[0] : s_lead;
  wire trail_ev = m_edge ? edge_cnt_reg[0] : s_trail;
  wire last_edge = edge_cnt_reg == {lm1, 1'b1};
  wire last_bit  = bit_cnt_reg == lm1;
  wire sample_ev = cpha ? trail_ev : lead_ev;
  wire drive_ev  = cpha ? lead_ev : (trail_ev && !last_edge);
  wire frame_done = mst ? (trail_ev && last_edge) : (sample_ev && last_bit);
  wire cs_fall   = cs_q_reg && !i_cs_b;
  wire start = en && (mst ? (state_reg == ssei_pkg::ST_IDLE && !tx_empty)
                          : ((state_reg == ssei_pkg::ST_IDLE && cs_fall) || (frame_done && !i_cs_b)));

  // Empty transmit FIFO at frame start resends the last loaded word
  wire [DW-1:0] tx_src  = tx_empty ? tx_last_reg : tx_head;
  wire [DW-1:0] tx_word = reorder(tx_src, lm1, config_word_one_reg.transmit_order_field);
  wire          tx_pop  = start && !tx_empty;
  wire          udr_set = start && tx_empty;
  wire [DW-1:0] rx_cap  = sample_ev ? {rx_sh_reg[DW-2:0], i_ser_in} : rx_sh_reg;
  wire [DW-1:0] rx_word = reorder(rx_cap, lm1, config_word_one_reg.receive_order_field);
  wire          rx_push = frame_done && !rx_full;
  wire          ovr_set = frame_done && rx_full;
  wire          to_set  = tick && !rx_empty && to_cnt_reg == ssei_pkg::TO_LAST;

  ssei_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_tx_fifo (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_push  (tx_push),
    .i_data  (i_wdata),
    .i_pop   (tx_pop),
    .o_data  (tx_head),
    .o_count (tx_cnt),
    .o_full  (tx_full),
    .o_empty (tx_empty)
  );

  ssei_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_rx_fifo (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_push  (rx_push),
    .i_data  (rx_word),
    .i_pop   (rx_pop),
    .o_data  (rx_head),
    .o_count (rx_cnt),
    .o_full  (rx_full),
    .o_empty (rx_empty)
  );

  assign raw_int[ssei_pkg::IRQ_RX]  = rx_cnt >= CW'(wmark_reg.rx_mark);
  assign raw_int[ssei_pkg::IRQ_TX]  = tx_cnt <= CW'(wmark_reg.tx_mark);
  assign raw_int[ssei_pkg::IRQ_TO]  = timeout_flag_reg;
  assign raw_int[ssei_pkg::IRQ_OVR] = overrun_flag_reg;
  assign raw_int[ssei_pkg::IRQ_UDR] = underrun_flag_reg;
  assign raw_int[ssei_pkg::IRQ_TXE] = tx_empty;

  wire ssei_pkg::ssei_stat_t stat = '{state_reg != ssei_pkg::ST_IDLE, rx_full, !rx_empty, !tx_full, tx_empty};

  always_comb begin
    rd_mux = '0;
    if (i_addr == ssei_pkg::OFF_CONFIG_WORD_ZERO) begin
      rd_mux = DW'(config_word_zero_reg);
    end else if (i_addr == ssei_pkg::OFF_CONFIG_WORD_ONE) begin
      rd_mux = DW'(config_word_one_reg);
    end else if (i_addr == ssei_pkg::OFF_DATA) begin
      rd_mux = rx_head;
    end else if (i_addr == ssei_pkg::OFF_STATUS) begin
      rd_mux = DW'(stat);
    end else if (i_addr == ssei_pkg::OFF_CLOCK_PRESCALE) begin
      rd_mux = DW'(clock_prescale_register_reg);
    end else if (i_addr == ssei_pkg::OFF_INT_MASK) begin
      rd_mux = DW'(interrupt_mask_register_reg);
    end else if (i_addr == ssei_pkg::OFF_RAW_STATUS) begin
      rd_mux = DW'(raw_int);
    end else if (i_addr == ssei_pkg::OFF_MASKED_STATUS) begin
      rd_mux = DW'(raw_int & interrupt_mask_register_reg);
    end else if (i_addr == ssei_pkg::OFF_WATERMARK) begin
      rd_mux = DW'(wmark_reg);
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ssei_pkg::ST_IDLE: begin
        if (start) state_next = ssei_pkg::ST_RUN;
      end
      ssei_pkg::ST_RUN: begin
        if (frame_done) state_next = mst ? ssei_pkg::ST_TAIL : (start ? ssei_pkg::ST_RUN : ssei_pkg::ST_IDLE);
        else if (!mst && i_cs_b) state_next = ssei_pkg::ST_IDLE;
      end
      ssei_pkg::ST_TAIL: begin
        if (tick) state_next = ssei_pkg::ST_GAP;
      end
      ssei_pkg::ST_GAP: begin
        if (tick) state_next = ssei_pkg::ST_IDLE;
      end
      default: state_next = ssei_pkg::ST_IDLE;
    endcase
    if (!en) state_next = ssei_pkg::ST_IDLE;
  end

  // Register port; clearing the enable leaves both FIFOs alone
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      config_word_zero_reg        <= ssei_pkg::CFG0_RST;
      config_word_one_reg         <= ssei_pkg::CFG1_RST;
      clock_prescale_register_reg <= ssei_pkg::PSC_RST;
      interrupt_mask_register_reg <= ssei_pkg::MASK_RST;
      wmark_reg                   <= ssei_pkg::WMARK_RST;
      o_rdata                     <= '0;
    end else begin
      if (wr_cfg0) config_word_zero_reg <= ssei_pkg::ssei_cfg0_t'({i_wdata[14:5], fix_len(i_wdata[4:0])});
      if (wr_cfg1) config_word_one_reg <= ssei_pkg::ssei_cfg1_t'(i_wdata[$bits(ssei_pkg::ssei_cfg1_t)-1:0]);
      if (wr_psc) clock_prescale_register_reg <= fix_psc(i_wdata[7:0]);
      if (wr_mask) interrupt_mask_register_reg <= i_wdata[ssei_pkg::NIRQ-1:0];
      if (wr_wm) wmark_reg <= ssei_pkg::ssei_wmark_t'(i_wdata[$bits(ssei_pkg::ssei_wmark_t)-1:0]);
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      timeout_flag_reg  <= 1'b0;
      overrun_flag_reg  <= 1'b0;
      underrun_flag_reg <= 1'b0;
      to_cnt_reg        <= '0;
      o_irq             <= 1'b0;
    end else begin
      if (to_set) timeout_flag_reg <= 1'b1;
      else if ((wr_clr && i_wdata[ssei_pkg::IRQ_TO]) || rx_push || rx_empty) timeout_flag_reg <= 1'b0;
      if (ovr_set) overrun_flag_reg <= 1'b1;
      else if (wr_clr && i_wdata[ssei_pkg::IRQ_OVR]) overrun_flag_reg <= 1'b0;
      if (udr_set) underrun_flag_reg <= 1'b1;
      else if (wr_clr && i_wdata[ssei_pkg::IRQ_UDR]) underrun_flag_reg <= 1'b0;
      if (rx_push || rx_empty || (wr_clr && i_wdata[ssei_pkg::IRQ_TO])) to_cnt_reg <= '0;
      else if (tick && to_cnt_reg != ssei_pkg::TO_LAST) to_cnt_reg <= to_cnt_reg + 1'b1;
      o_irq <= |(raw_int & interrupt_mask_register_reg);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_reg    <= ssei_pkg::ST_IDLE;
      div_cnt_reg  <= '0;
      edge_cnt_reg <= '0;
      bit_cnt_reg  <= '0;
      sclk_q_reg   <= 1'b0;
      cs_q_reg     <= 1'b1;
      o_sclk       <= 1'b0;
      o_cs_b       <= 1'b1;
      o_ser_out_oe <= 1'b0;
    end else begin
      state_reg    <= state_next;
      div_cnt_reg  <= (!en || tick || start) ? '0 : div_cnt_reg + 1'b1;
      edge_cnt_reg <= start ? '0 : edge_cnt_reg + 6'(lead_ev || trail_ev);
      bit_cnt_reg  <= start ? '0 : bit_cnt_reg + 5'(sample_ev);
      sclk_q_reg   <= i_sclk;
      cs_q_reg     <= i_cs_b;
      o_sclk       <= (mst && running) ? (o_sclk ^ m_edge) : cpol;
      if (!en || !mst || (state_reg == ssei_pkg::ST_TAIL && tick)) o_cs_b <= 1'b1;
      else if (start) o_cs_b <= 1'b0;
      // Slave drives its output only while selected
      o_ser_out_oe <= en && (mst || !i_cs_b);
    end
  end

  // Shift registers, last loaded word and serial output all clear on reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tx_sh_reg   <= '0;
      rx_sh_reg   <= '0;
      tx_last_reg <= '0;
      o_ser_out   <= 1'b0;
    end else begin
      if (tx_pop) tx_last_reg <= tx_head;
      if (start && !cpha) begin
        o_ser_out <= tx_word[lm1];
        tx_sh_reg <= tx_word << 1;
      end else if (start) begin
        tx_sh_reg <= tx_word;
      end else if (drive_ev) begin
        o_ser_out <= tx_sh_reg[lm1];
        tx_sh_reg <= tx_sh_reg << 1;
      end
      if (sample_ev) rx_sh_reg <= rx_cap;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_master_done;
    en && mst && frame_done;
  endsequence

  sequence s_tail_to_gap;
    en && state_reg == ssei_pkg::ST_TAIL && tick;
  endsequence

  a_done_holds_select: assert property (s_master_done |=> state_reg == ssei_pkg::ST_TAIL && !o_cs_b)
    else $error("select released before tail half period");
  a_cs_word_gap: assert property (s_tail_to_gap |=> o_cs_b && state_reg == ssei_pkg::ST_GAP)
    else $error("no high select pulse between words");
  a_idle_clk_level: assert property (en && mst && state_reg == ssei_pkg::ST_IDLE |=> o_sclk == $past(cpol))
    else $error("serial clock not at idle level");
  a_clk_half_steady: assert property (mst && running && !tick |=> $stable(o_sclk))
    else $error("serial clock changed between divider ticks");
  a_phase0_first_bit: assert property (start && !cpha |=> o_ser_out == $past(tx_word[lm1]))
    else $error("first bit not presented before first edge");
  a_phase1_drive: assert property (lead_ev && cpha && !start |=> o_ser_out == $past(tx_sh_reg[lm1]))
    else $error("phase one data not driven on leading edge");
  a_fifo_kept_off: assert property (!en && !i_wr && !i_rd |=> $stable(tx_cnt) && $stable(rx_cnt))
    else $error("FIFO level moved while disabled");
  a_overrun_keeps: assert property (ovr_set && !rx_pop |=> raw_int[ssei_pkg::IRQ_OVR] && rx_cnt == $past(rx_cnt))
    else $error("overrun lost or FIFO changed");
  a_underrun_set: assert property (udr_set |=> raw_int[ssei_pkg::IRQ_UDR])
    else $error("underrun not flagged");
  a_timeout_set: assert property (to_set |=> raw_int[ssei_pkg::IRQ_TO])
    else $error("timeout not flagged");
  a_timeout_clear: assert property (rx_push && !to_set |=> !raw_int[ssei_pkg::IRQ_TO])
    else $error("timeout kept after new frame");
  a_irq_masked: assert property (##1 o_irq == $past(|(raw_int & interrupt_mask_register_reg)))
    else $error("interrupt output does not follow masked status");
endmodule

// file: ssei_fifo.sv
// Flip-flop FIFO for the transmit and receive data paths
`timescale 1ns/1ps
module ssei_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_push,
  input  wire logic [WIDTH-1:0]         i_data,
  input  wire logic                     i_pop,
  output logic      [WIDTH-1:0]         o_data,
  output logic      [$clog2(DEPTH):0]   o_count,
  output logic                          o_full,
  output logic                          o_empty
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;

  // Push into a full FIFO is dropped; pop of an empty one is ignored
  wire do_push = i_push && !o_full;
  wire do_pop  = i_pop && !o_empty;

  assign o_full  = count_reg == (PW+1)'(DEPTH);
  assign o_empty = count_reg == '0;
  assign o_count = count_reg;
  assign o_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(do_push);
      rd_ptr_reg <= rd_ptr_reg + PW'(do_pop);
      count_reg  <= count_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end
endmodule

// file: ssei_pkg.sv
// Constants, register map and types of the serial engine
package ssei_pkg;
  localparam int DATA_W   = 32;
  localparam int BYTE_W   = 8;
  localparam int ADDR_W   = 6;
  localparam int FIFO_DEP = 16;
  localparam int NIRQ     = 6;
  localparam int DIV_W    = 15;
  localparam int TO_W     = 7;

  localparam logic [ADDR_W-1:0] OFF_CONFIG_WORD_ZERO = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_CONFIG_WORD_ONE  = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_DATA             = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS           = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_PRESCALE   = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK         = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_RAW_STATUS       = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_MASKED_STATUS    = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_INT_CLEAR        = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_WATERMARK        = 6'h24;

  localparam int IRQ_RX  = 0;
  localparam int IRQ_TX  = 1;
  localparam int IRQ_TO  = 2;
  localparam int IRQ_OVR = 3;
  localparam int IRQ_UDR = 4;
  localparam int IRQ_TXE = 5;

  localparam logic [1:0] ORD_MSB_MSB = 2'h0;
  localparam logic [1:0] ORD_LSB_MSB = 2'h1;
  localparam logic [1:0] ORD_MSB_LSB = 2'h2;
  localparam logic [1:0] ORD_LSB_LSB = 2'h3;

  localparam logic [7:0]        PSC_MIN    = 8'h02;
  localparam logic [4:0]        LEN_M1_MIN = 5'h03;
  localparam logic [DATA_W-1:0] LOW_MASK   = 32'hFFFFFFFE;
  localparam logic [TO_W-1:0]   TO_LAST    = 7'h3F;

  typedef struct packed {
    logic [7:0] serial_clock_rate_field;
    logic       clock_polarity_select;
    logic       clock_phase_select;
    logic [4:0] frame_len_m1;
  } ssei_cfg0_t;

  typedef struct packed {
    logic [1:0] receive_order_field;
    logic [1:0] transmit_order_field;
    logic       master_role;
    logic       port_enable_bit;
  } ssei_cfg1_t;

  typedef struct packed {
    logic [4:0] rx_mark;
    logic [4:0] tx_mark;
  } ssei_wmark_t;

  typedef struct packed {
    logic busy;
    logic rx_full;
    logic rx_not_empty;
    logic tx_not_full;
    logic tx_empty;
  } ssei_stat_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TAIL, ST_GAP} ssei_state_t;

  localparam ssei_cfg0_t  CFG0_RST  = '{8'h00, 1'b0, 1'b0, 5'h07};
  localparam ssei_cfg1_t  CFG1_RST  = '{2'h0, 2'h0, 1'b0, 1'b0};
  localparam ssei_wmark_t WMARK_RST = '{5'h08, 5'h08};
  localparam logic [7:0]  PSC_RST   = 8'h02;
  localparam logic [NIRQ-1:0] MASK_RST = 6'h00;
endpackage

// file: ssei_slave_model.sv
// External slave device model on the serial link
`timescale 1ns/1ps
module ssei_slave_model (
  input  wire logic        i_sclk,
  input  wire logic        i_cs_b,
  input  wire logic        i_mosi,
  input  wire logic        i_cpha,
  input  wire logic        i_cpol,
  input  wire logic [15:0] i_reply,
  output logic             o_miso,
  output logic [15:0]      o_got
);
  logic [15:0] sh = '0;
  logic        lead;
  initial o_miso = 1'b0;
  initial o_got = '0;
  always @(negedge i_cs_b) begin
    o_got = '0;
    sh = i_reply;
    if (!i_cpha) begin
      o_miso = sh[15];
      sh = sh << 1;
    end
  end
  // Clock ignored while deselected; idle toggles of polarity are harmless
  always @(i_sclk) if (!i_cs_b) begin
    lead = (i_sclk !== i_cpol);
    if (lead == !i_cpha) begin
      o_got = {o_got[14:0], i_mosi};
    end else begin
      o_miso = sh[15];
      sh = sh << 1;
    end
  end
  // Released line must not hold the last bit
  always @(posedge i_cs_b) o_miso = ~o_miso;
endmodule

// file: test_spi_serial_engine_irq.sv
// Register-port tests of the serial engine against a slave model
`timescale 1ns/1ps
module test_spi_serial_engine_irq;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [5:0]  addr = '0;
  logic [31:0] wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata, rv, tx;
  logic        irq, sclk, cs_b, mosi, oe, miso;
  logic        mpha = 1'b0;
  logic        mpol = 1'b0;
  logic [15:0] got;
  logic        s_mode = 1'b0;
  logic        s_clk = 1'b0;
  logic        s_cs_b = 1'b1;
  logic        s_mosi = 1'b0;
  logic [7:0]  s_got = '0;
  int          fail_count = 0;
  int          n_tests = 0;
  always #4 clk = ~clk;
  ssei_core dut (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .o_sclk(sclk), .i_sclk(s_clk), .o_cs_b(cs_b),
    .i_cs_b(s_cs_b), .i_ser_in(s_mode ? s_mosi : miso), .o_ser_out(mosi), .o_ser_out_oe(oe));
  ssei_slave_model peer (.i_sclk(sclk), .i_cs_b(cs_b), .i_mosi(mosi), .i_cpha(mpha),
    .i_cpol(mpol), .i_reply(16'h5A0F), .o_miso(miso), .o_got(got));
  // Bit 0 of order swaps bytes, bit 1 reverses bits in each byte
  function automatic logic [15:0] map16(input logic [15:0] w, input logic [1:0] o);
    logic [15:0] r;
    logic [15:0] b;
    r = o[0] ? {w[7:0], w[15:8]} : w;
    for (int i = 0; i < 16; i++) b[i] = r[(i & 8) + 7 - (i & 7)];
    return o[1] ? b : r;
  endfunction
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // Host of a slave-role frame, phase 0 polarity 0; each clock level held two cycles
  task automatic host_frame(input logic [7:0] d);
    @(posedge clk);
    s_cs_b <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      s_mosi <= d[i];
      repeat (2) @(posedge clk);
      s_got[i] = mosi;
      s_clk <= 1'b1;
      repeat (2) @(posedge clk);
      s_clk <= 1'b0;
    end
    repeat (2) @(posedge clk);
    s_cs_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t ns: got 0x%0h expected 0x%0h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #160000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(ssei_pkg::OFF_CONFIG_WORD_ZERO);
    chk(rv, 32'h00000007);
    rd_reg(6'h3C);
    chk(rv, 32'h00000000);
    rd_reg(ssei_pkg::OFF_RAW_STATUS);
    chk(rv, 32'h00000022);
    wr_reg(ssei_pkg::OFF_INT_MASK, 32'h00000006);
    wr_reg(ssei_pkg::OFF_WATERMARK, 32'h00000028);
    rd_reg(ssei_pkg::OFF_MASKED_STATUS);
    chk(rv, 32'h00000002);
    chk({31'h0, irq}, 32'h00000001);
    wr_reg(ssei_pkg::OFF_CLOCK_PRESCALE, 32'h00000004);
    for (int k = 0; k < 4; k++) begin
      tx = 32'h0000A5C3 + 32'(k);
      mpha <= k[0];
      mpol <= k[1];
      wr_reg(ssei_pkg::OFF_CONFIG_WORD_ZERO, {25'h0, k[1:0], 5'h0F});
      wr_reg(ssei_pkg::OFF_DATA, tx);
      wr_reg(ssei_pkg::OFF_CONFIG_WORD_ONE, {26'h0, k[1:0], k[1:0], 2'h2});
      rd_reg(ssei_pkg::OFF_STATUS);
      chk(rv, 32'h00000002);
      wr_reg(ssei_pkg::OFF_CONFIG_WORD_ONE, {26'h0, k[1:0], k[1:0], 2'h3});
      rv = 'x;
      for (int i = 0; i < 100 && rv !== 32'h7; i++) rd_reg(ssei_pkg::OFF_STATUS);
      chk(rv, 32'h00000007);
      chk({16'h0, got}, {16'h0, map16(tx[15:0], k[1:0])});
      chk({29'h0, oe, cs_b, sclk}, {29'h0, 1'b1, 1'b1, k[1]});
      repeat (140) @(posedge clk);
      rd_reg(ssei_pkg::OFF_RAW_STATUS);
      chk(rv, 32'h00000027);
      wr_reg(ssei_pkg::OFF_INT_CLEAR, 32'h00000004);
      wr_reg(ssei_pkg::OFF_CONFIG_WORD_ONE, 32'h00000002);
      rd_reg(ssei_pkg::OFF_RAW_STATUS);
      chk(rv, 32'h00000023);
      rd_reg(ssei_pkg::OFF_DATA);
      chk(rv, {16'h0, map16(16'h5A0F, k[1:0])});
      rd_reg(ssei_pkg::OFF_RAW_STATUS);
      chk(rv, 32'h00000022);
    end
    // Slave role: second frame under a held select finds the FIFO empty
    wr_reg(ssei_pkg::OFF_CONFIG_WORD_ZERO, 32'h00000007);
    s_mode <= 1'b1;
    wr_reg(ssei_pkg::OFF_DATA, 32'h00000096);
    wr_reg(ssei_pkg::OFF_CONFIG_WORD_ONE, 32'h00000001);
    host_frame(8'h3C);
    chk({24'h0, s_got}, 32'h00000096);
    rd_reg(ssei_pkg::OFF_RAW_STATUS);
    chk(rv, 32'h00000033);
    rd_reg(ssei_pkg::OFF_DATA);
    chk(rv, 32'h0000003C);
    wr_reg(ssei_pkg::OFF_INT_CLEAR, 32'h00000010);
    rd_reg(ssei_pkg::OFF_RAW_STATUS);
    chk(rv, 32'h00000022);
    test_done();
  end
endmodule
